/* File: verilog/ccmd_top.sv */
// Purpose: Module disable register with Wishbone access
// Assumes: Classic Wishbone, 32-bit data, one clock
// Notes: Unmapped reads return zero and still ack
`timescale 1ns/1ps
`include "ccmd_consts.svh"
module ccmd_top
  import ccmd_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output ccmd_disable_t disable_o,
  output logic [5:0] run_o
);
  logic [15:0] reg_q; // Disable register, 16 bits
  logic [15:0] reg_d; // Next value on write
  logic req; // New request this cycle
  logic [5:0] off_vec; // Disable bits in struct order
  logic [5:0] run_int; // Gated enables from the leaf

  // Single-cycle answer; ack drops the cycle after
  assign req = cyc_i & stb_i & ~ack_o;

  // Byte lanes merge; unimplemented bits stay zero
  always_comb
  begin
    reg_d = reg_q;
    if (sel_i[0])
      reg_d[7:0] = dat_i[7:0];
    if (sel_i[1])
      reg_d[15:8] = dat_i[15:8];
    reg_d = reg_d & `CCMD_IMPL_MASK;
  end

  // Register write, reset clears every disable
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      reg_q <= `CCMD_RESET_VALUE; // R7
    else if (req && we_i && adr_i == `CCMD_DISABLE_OFFSET)
      reg_q <= reg_d; // R1 R2 R3 R4 R5 R7
  end

  // Acknowledge every request, mapped or not
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_o <= 1'b0;
    else
      ack_o <= req;
  end

  // Read data; status shows live channel enables
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      dat_o <= 32'h0000_0000;
    else if (req && !we_i)
    begin
      case (adr_i)
        `CCMD_DISABLE_OFFSET: dat_o <= {16'h0000, reg_q};
        `CCMD_STATUS_OFFSET: dat_o <= {26'h0, run_int};
        default: dat_o <= 32'h0000_0000;
      endcase
    end
    else
      dat_o <= 32'h0000_0000;
  end

  // Pick channel bits out of the register
  assign off_vec = {reg_q[`CCMD_IC3_BIT], // R1
                    reg_q[`CCMD_IC2_BIT], // R2
                    reg_q[`CCMD_IC1_BIT], // R3
                    reg_q[`CCMD_OC3_BIT], // R4
                    reg_q[`CCMD_OC2_BIT], // R5
                    reg_q[`CCMD_OC1_BIT]}; // R7

  // Disable outputs registered copy of the bits
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      disable_o <= '0;
    else
      disable_o <= off_vec;
  end

  // Enables: one means power and clock on
  ccmd_gate #(.N(6)) u_gate (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .off_i(off_vec),
    .run_o(run_int)
  );
  assign run_o = run_int; // Leaf output is already a flop
endmodule : ccmd_top

/* File: verilog/ccmd_consts.svh */
// Purpose: Constants for the capture/compare module disable register
// Assumes: Included by bare name; definitions only
// Notes: Offsets are byte addresses on a 32-bit Wishbone bus
// How it works
// R1 - Bit 10 disables input capture three
// R2 - Bit 9 disables input capture two
// R3 - Bit 8 disables input capture one
// R4 - Bit 2 disables output compare three
// R5 - Bit 1 disables output compare two
// R6 - Zero keeps power and clock enabled
// R7 - Bit 0 disables compare one; reset zero
`ifndef CCMD_CONSTS_SVH
`define CCMD_CONSTS_SVH
`define CCMD_DISABLE_OFFSET 8'h00
`define CCMD_STATUS_OFFSET 8'h04
`define CCMD_IC3_BIT 10
`define CCMD_IC2_BIT 9
`define CCMD_IC1_BIT 8
`define CCMD_OC3_BIT 2
`define CCMD_OC2_BIT 1
`define CCMD_OC1_BIT 0
`define CCMD_IMPL_MASK 16'h0707
`define CCMD_RESET_VALUE 16'h0000
`endif

/* File: verilog/ccmd_pkg.sv */
// Purpose: Types for the capture/compare module disable block
// Assumes: Nothing beyond the constants header
// Notes: Channel order is ic3..ic1 then oc3..oc1
package ccmd_pkg;
  // One bit per channel, one means gated off
  typedef struct packed {
    logic input_capture_three_off;
    logic input_capture_two_off;
    logic input_capture_one_off;
    logic output_compare_three_off;
    logic output_compare_two_off;
    logic output_compare_one_off;
  } ccmd_disable_t;
endpackage : ccmd_pkg

/* File: verilog/ccmd_gate.sv */
// Purpose: Per-channel power and clock enable from disable bits
// Assumes: Single clock, synchronous active-high reset
// Notes: Enables are registered so they are glitch free
`timescale 1ns/1ps
module ccmd_gate
  import ccmd_pkg::*;
#(
  parameter int N = 6
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [N-1:0] off_i,
  output logic [N-1:0] run_o
);
  // One enable flop per channel
  genvar g;
  generate
    for (g = 0; g < N; g++)
    begin : g_ch
      // Reset comes up enabled, matching cleared disables
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
          run_o[g] <= 1'b1;
        else
          run_o[g] <= ~off_i[g]; // R6
      end
    end
  endgenerate
endmodule : ccmd_gate

/* File: test/ccmd_checker.sv */
// Purpose: Port checks for the module disable register
// Assumes: Full 16-bit writes with both byte lanes
// Notes: Bound to ccmd_top from the bench top file
`timescale 1ns/1ps
module ccmd_checker
  import ccmd_pkg::*;
(
  input logic clk_i,
  input logic rst_i,
  input logic we_i,
  input logic [7:0] adr_i,
  input logic [3:0] sel_i,
  input logic [31:0] dat_i,
  input logic ack_o,
  input ccmd_disable_t disable_o,
  input logic [5:0] run_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Acked write to the disable register; outputs follow one edge later
  wire wr = ack_o && we_i && adr_i == 8'h00 && sel_i == 4'h3;
  ic3_off_a: assert property (wr |=> disable_o[5] == $past(dat_i[10]))
    else $error("ic3 disable wrong");
  ic2_off_a: assert property (wr |=> disable_o[4] == $past(dat_i[9]))
    else $error("ic2 disable wrong");
  ic1_off_a: assert property (wr |=> disable_o[3] == $past(dat_i[8]))
    else $error("ic1 disable wrong");
  oc3_off_a: assert property (wr |=> disable_o[2] == $past(dat_i[2]))
    else $error("oc3 disable wrong");
  oc2_off_a: assert property (wr |=> disable_o[1] == $past(dat_i[1]))
    else $error("oc2 disable wrong");
  oc1_off_a: assert property (wr |=> disable_o[0] == $past(dat_i[0]))
    else $error("oc1 disable wrong");
  // Enables must never disagree with the disable bits
  run_inv_a: assert property (run_o == ~disable_o)
    else $error("run not inverse");
  cover property (wr);
  cover property (ack_o && !we_i);
  cover property (wr && dat_i[10]);
endmodule : ccmd_checker

/* File: test/capture_module_disable_bits_bench.sv */
// Purpose: Register bench for the module disable block
// Assumes: One ack per request, outputs lag the ack by one edge
// Notes: Each bit is walked alone, then all bits at once
`timescale 1ns/1ps
module capture_module_disable_bits_bench;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0;
  logic we_i = 1'b0, ack_o;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'h3;
  logic [31:0] dat_i = 32'h0, dat_o, rd;
  logic [5:0] disable_o, run_o;
  int bad_count = 0, compares = 0, ticks = 0;
  ccmd_top dut_u (.*);
  always #5 clk_i = ~clk_i;
  // Ceiling well above the fewer than a hundred cycles the tests need
  always @(posedge clk_i)
    if (++ticks > 400)
    begin
      bad_count++;
      complete_run();
    end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  // One classic cycle; read data is taken at the ack edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'h3, w, a, d, 4'h3};
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rd = dat_o;
    {cyc_i, stb_i} <= 2'h0;
  endtask : wb
  task automatic complete_run();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run
  initial
  begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, 8'h00, 32'h0);
    chk({rd[31:6], run_o}, 32'h3f);
    // Walk one disable bit at a time
    for (int i = 0; i < 6; i++)
    begin
      wb(1'b1, 8'h00, 32'h1 << (i < 3 ? i : i + 5));
      wb(1'b0, 8'h00, 32'h0);
      chk(rd, 32'h1 << (i < 3 ? i : i + 5));
      chk({run_o, disable_o}, {~(6'h1 << i), 6'h1 << i});
    end
    $display("bit walk done");
    // Unimplemented bits, the unmapped place and the all-off status read as zero
    wb(1'b1, 8'h00, 32'hffff_ffff);
    wb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h0707);
    wb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h0);
    wb(1'b1, 8'h08, 32'h0);
    wb(1'b0, 8'h08, 32'h0);
    chk({rd, disable_o}, {32'h0, 6'h3f});
    $display("mask test done");
    // Mid-run reset must clear every disable and re-enable all channels
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h3f);
    chk({run_o, disable_o}, {6'h3f, 6'h00});
    $display("reset test done");
    complete_run();
  end
endmodule : capture_module_disable_bits_bench
bind ccmd_top ccmd_checker chk_u (.*);
